/* verilog/livet_pkg.sv */
// constants and types for the local interrupt, error and timer block
//------------------------------------------------------------
// Functional notes
// - handed to core, not accepted: status one
// - polarity zero high, one low
// - fixed level: flag set on accept, cleared by eoi
// - pins: trigger zero edge, one level, fixed only
// - smi nmi init edge, external_controller_delivery level, timer/error edge
// - mask zero accepts, mask one inhibits
// - perf delivery sets its mask, software clears
// - timer mode zero one-shot, one periodic
// - vectors 16-255 valid, 0-15 flagged illegal in fixed mode
// - vectors 16-31 are not illegal
// - any new error bit raises error interrupt
// - write before read loads latest errors
// - error bits sticky, back-to-back writes clear
// - send and receive illegal vector bits
// - reserved region access sets address error
// - extended mode: fault on nonzero or reserved
// - illegal received vector: no delivery, flag only
// - lowest priority command: redirect error, no send
// - 32-bit down counter on divided clock
// - one-shot: load, count, fire once, hold zero
// - periodic: fire, reload, keep counting
// - initial write restarts; current count read-only
// - delivery mode codes decoded
// - idle status once accepted or nothing pending
//------------------------------------------------------------
package livet_pkg;
  // source slots in the local table
  localparam int NSRC = 6;
  localparam int SRC_TIMER = 0;
  localparam int SRC_THERM = 1;
  localparam int SRC_PERF = 2;
  localparam int SRC_PIN0 = 3;
  localparam int SRC_PIN1 = 4;
  localparam int SRC_ERR = 5;
  // register regions inside the 4 KByte window
  localparam logic [11:0] REGION_MASK = 12'hFF0;
  localparam logic [NSRC-1:0][11:0] LVT_OFF = {
    12'h370, 12'h360, 12'h350, 12'h340, 12'h330, 12'h320};
  localparam logic [11:0] OFF_ESR = 12'h280;
  localparam logic [11:0] OFF_ICR = 12'h300;
  localparam logic [11:0] OFF_INIT = 12'h380;
  localparam logic [11:0] OFF_CUR = 12'h390;
  localparam logic [11:0] OFF_DIV = 12'h3E0;
  // entry field positions
  localparam int F_MODE = 8;
  localparam int F_STAT = 12;
  localparam int F_POL = 13;
  localparam int F_LIS = 14;
  localparam int F_TRIG = 15;
  localparam int F_MASK = 16;
  localparam int F_TMODE = 17;
  localparam logic ENT_MASK_RST = 1'b1;
  // delivery mode codes
  localparam logic [2:0] MODE_FIXED = 3'h0;
  localparam logic [2:0] MODE_LOWEST = 3'h1;
  localparam logic [2:0] MODE_SMI = 3'h2;
  localparam logic [2:0] MODE_NMI = 3'h4;
  localparam logic [2:0] MODE_INIT = 3'h5;
  localparam logic [2:0] MODE_EXTERNAL_CONTROLLER_DELIVERY = 3'h7;
  // error status bit positions
  localparam int E_REDIR = 4;
  localparam int E_SILL = 5;
  localparam int E_RILL = 6;
  localparam int E_ILLADR = 7;
  localparam logic [7:0] VEC_MIN_LEGAL = 8'h10;
  localparam int DIV_W = 3;
  localparam logic [31:0] CNT_ONE = 32'h1;
  // one table entry
  typedef struct packed {
    logic tmode;
    logic mask;
    logic trig;
    logic lis;
    logic pol;
    logic stat;
    logic [2:0] mode;
    logic [7:0] vec;
  } livet_entry_t;
endpackage

/* verilog/livet_top.sv */
// local interrupt table, error status and timer for one core
`timescale 1ns/100ps
module livet_top #(
  parameter int PRESC_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic gp_fault,
  input wire logic local_pin_zero,
  input wire logic local_pin_one,
  input wire logic thermal_evt,
  input wire logic perf_evt,
  output logic del_valid,
  output logic [7:0] del_vector,
  output logic [2:0] del_mode,
  output logic [2:0] del_src,
  input wire logic core_accept,
  input wire logic end_of_service_command,
  input wire logic [7:0] eoi_vector,
  output logic msg_valid,
  output logic [7:0] msg_vector,
  output logic [2:0] msg_mode
);
  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef struct packed {
    livet_pkg::livet_entry_t [livet_pkg::NSRC-1:0] ent;
    logic [livet_pkg::NSRC-1:0] pend; // latched requests
    logic [1:0] sy0; // pin sync, first stage
    logic [1:0] sy1; // pin sync, second stage
    logic [1:0] prev; // last active level of pins
    logic dv; // delivery waiting for accept
    logic [7:0] dvec;
    logic [2:0] dmode;
    logic [2:0] dsrc;
    logic mv; // outgoing message pulse
    logic [7:0] mvec;
    logic [2:0] mmode;
    logic [31:0] message_command_register;
    logic [31:0] error_status_flags; // software-visible copy
    logic [31:0] acc; // running accumulation
    logic esr_last; // previous access was an esr write that loaded the errors
    logic [31:0] init;
    logic [31:0] cur;
    logic run;
    logic [livet_pkg::DIV_W-1:0] div;
    logic [PRESC_W-1:0] presc;
    logic ack;
    logic [31:0] rdata;
    logic gp;
  } livet_state_t;

  livet_state_t q; // registered state
  livet_state_t d; // next state
  logic [11:0] rgn; // 16-byte region of the access
  logic lvt_hit;
  logic [2:0] lvt_idx;
  logic mapped;
  logic acc_en; // any access this cycle
  logic [31:0] rd;
  logic [31:0] new_err;
  logic [livet_pkg::NSRC-1:0] raise;
  logic [PRESC_W-1:0] dmask;
  logic tick;
  logic act;
  logic lvl;
  logic found;
  logic ill;

  // pack an entry into its register word
  function automatic logic [31:0] ent_word(
    input livet_pkg::livet_entry_t e);
    logic [31:0] w;
    w = 32'(e.vec);
    w = w | (32'(e.mode) << livet_pkg::F_MODE);
    w = w | (32'(e.stat) << livet_pkg::F_STAT);
    w = w | (32'(e.pol) << livet_pkg::F_POL);
    w = w | (32'(e.lis) << livet_pkg::F_LIS);
    w = w | (32'(e.trig) << livet_pkg::F_TRIG);
    w = w | (32'(e.mask) << livet_pkg::F_MASK);
    w = w | (32'(e.tmode) << livet_pkg::F_TMODE);
    return w;
  endfunction

  //------------------------------------------------------------
  // next-state logic
  //------------------------------------------------------------
  // order matters: software first, hardware sets last so they win
  always_comb begin
    d = q;
    new_err = '0;
    raise = '0;
    rd = '0;
    lvt_hit = 1'b0;
    lvt_idx = '0;
    found = 1'b0;
    act = 1'b0;
    lvl = 1'b0;
    ill = 1'b0;
    rgn = reg_addr & livet_pkg::REGION_MASK;
    acc_en = reg_wr | reg_rd;
    d.ack = acc_en;
    d.gp = 1'b0;
    d.mv = 1'b0;
    // pins cross in through two flops
    d.sy0 = {local_pin_one, local_pin_zero};
    d.sy1 = q.sy0;
    // free-running prescaler for the timer
    d.presc = q.presc + PRESC_W'(1);
    dmask = PRESC_W'((1 << q.div) - 1);
    tick = &(q.presc | ~dmask);
    // address decode on 16-byte regions
    for (int i = 0; i < livet_pkg::NSRC; i++) begin
      if (rgn == livet_pkg::LVT_OFF[i]) begin
        lvt_hit = 1'b1;
        lvt_idx = 3'(i);
      end
    end
    mapped = lvt_hit || rgn == livet_pkg::OFF_ESR ||
      rgn == livet_pkg::OFF_ICR || rgn == livet_pkg::OFF_INIT ||
      rgn == livet_pkg::OFF_CUR || rgn == livet_pkg::OFF_DIV;
    // read mux
    if (lvt_hit) begin
      rd = ent_word(q.ent[lvt_idx]);
    end
    case (rgn)
      livet_pkg::OFF_ESR: rd = q.error_status_flags;
      livet_pkg::OFF_ICR: rd = q.message_command_register;
      livet_pkg::OFF_INIT: rd = q.init;
      livet_pkg::OFF_CUR: rd = q.cur;
      livet_pkg::OFF_DIV: rd = 32'(q.div);
      default: ;
    endcase
    if (reg_rd) begin
      d.rdata = rd;
    end
    // reserved regions
    if (acc_en && !mapped) begin
      if (ext_mode) begin
        d.gp = 1'b1;
      end else begin
        new_err[livet_pkg::E_ILLADR] = 1'b1;
      end
    end
    // any other access breaks a back-to-back esr pair
    if (acc_en) begin
      d.esr_last = 1'b0;
    end
    // table entry writes; status and in-service stay read-only
    if (reg_wr && lvt_hit) begin
      d.ent[lvt_idx].vec = reg_wdata[7:0];
      d.ent[lvt_idx].mode = reg_wdata[livet_pkg::F_MODE +: 3];
      d.ent[lvt_idx].pol = reg_wdata[livet_pkg::F_POL];
      d.ent[lvt_idx].trig = reg_wdata[livet_pkg::F_TRIG];
      d.ent[lvt_idx].mask = reg_wdata[livet_pkg::F_MASK];
      if (lvt_idx == 3'(livet_pkg::SRC_TIMER)) begin
        d.ent[lvt_idx].tmode = reg_wdata[livet_pkg::F_TMODE];
      end
    end
    // error status write
    if (reg_wr && rgn == livet_pkg::OFF_ESR) begin
      if (ext_mode && reg_wdata != '0) begin
        d.gp = 1'b1;
      end else if (q.esr_last) begin
        d.error_status_flags = '0;
        d.acc = '0;
      end else begin
        d.error_status_flags = q.acc;
        d.esr_last = 1'b1;
      end
    end
    // outgoing message command
    if (reg_wr && rgn == livet_pkg::OFF_ICR) begin
      d.message_command_register = reg_wdata;
      if (reg_wdata[livet_pkg::F_MODE +: 3] ==
          livet_pkg::MODE_LOWEST) begin
        new_err[livet_pkg::E_REDIR] = 1'b1;
      end else if (reg_wdata[livet_pkg::F_MODE +: 3] ==
          livet_pkg::MODE_FIXED &&
          reg_wdata[7:0] < livet_pkg::VEC_MIN_LEGAL) begin
        new_err[livet_pkg::E_SILL] = 1'b1;
      end else begin
        d.mv = 1'b1;
        d.mvec = reg_wdata[7:0];
        d.mmode = reg_wdata[livet_pkg::F_MODE +: 3];
      end
    end
    // divide setting
    if (reg_wr && rgn == livet_pkg::OFF_DIV) begin
      d.div = reg_wdata[livet_pkg::DIV_W-1:0];
    end
    // timer: a write to initial count restarts it; a write of zero stops it
    if (reg_wr && rgn == livet_pkg::OFF_INIT) begin
      d.init = reg_wdata;
      d.cur = reg_wdata;
      d.run = reg_wdata != '0;
    end else if (q.run && tick) begin
      if (q.cur == livet_pkg::CNT_ONE) begin
        raise[livet_pkg::SRC_TIMER] = 1'b1;
        if (q.ent[livet_pkg::SRC_TIMER].tmode) begin
          d.cur = q.init;
        end else begin
          d.cur = '0;
          d.run = 1'b0;
        end
      end else begin
        d.cur = q.cur - livet_pkg::CNT_ONE;
      end
    end
    // core takes the outstanding delivery
    if (q.dv && core_accept) begin
      d.dv = 1'b0;
      d.ent[q.dsrc].stat = 1'b0;
      if (q.dmode == livet_pkg::MODE_FIXED &&
          q.ent[q.dsrc].trig &&
          (q.dsrc == 3'(livet_pkg::SRC_PIN0) ||
           q.dsrc == 3'(livet_pkg::SRC_PIN1))) begin
        d.ent[q.dsrc].lis = 1'b1;
      end
    end
    // end of service drops matching in-service flags
    if (end_of_service_command) begin
      for (int i = 0; i < livet_pkg::NSRC; i++) begin
        if (q.ent[i].lis && q.ent[i].vec == eoi_vector) begin
          d.ent[i].lis = 1'b0;
        end
      end
    end
    // pick lowest pending source when the core link is free
    if (!q.dv) begin
      for (int i = 0; i < livet_pkg::NSRC; i++) begin
        if (q.pend[i] && !found) begin
          found = 1'b1;
          d.pend[i] = 1'b0;
          // vectors 16..31 pass; only 0..15 are refused
          ill = q.ent[i].mode == livet_pkg::MODE_FIXED &&
            q.ent[i].vec < livet_pkg::VEC_MIN_LEGAL;
          if (ill) begin
            new_err[livet_pkg::E_RILL] = 1'b1;
          end else begin
            d.dv = 1'b1;
            d.dvec = q.ent[i].vec;
            d.dmode = q.ent[i].mode;
            d.dsrc = 3'(i);
            d.ent[i].stat = 1'b1;
            if (i == livet_pkg::SRC_PERF) begin
              d.ent[i].mask = 1'b1;
            end
          end
        end
      end
    end
    // same-clock event sources, edge only
    raise[livet_pkg::SRC_THERM] = thermal_evt;
    raise[livet_pkg::SRC_PERF] = perf_evt;
    // pins: level or edge by mode and trigger bit
    for (int i = 0; i < 2; i++) begin
      act = q.sy1[i] ^ q.ent[livet_pkg::SRC_PIN0 + i].pol;
      lvl = q.ent[livet_pkg::SRC_PIN0 + i].mode ==
        livet_pkg::MODE_EXTERNAL_CONTROLLER_DELIVERY ||
        (q.ent[livet_pkg::SRC_PIN0 + i].mode ==
         livet_pkg::MODE_FIXED &&
         q.ent[livet_pkg::SRC_PIN0 + i].trig);
      d.prev[i] = act;
      if (lvl) begin
        // level holds request until serviced, not latched
        d.pend[livet_pkg::SRC_PIN0 + i] = act &&
          !q.ent[livet_pkg::SRC_PIN0 + i].mask &&
          !q.ent[livet_pkg::SRC_PIN0 + i].lis &&
          !q.ent[livet_pkg::SRC_PIN0 + i].stat &&
          !d.ent[livet_pkg::SRC_PIN0 + i].stat;
      end else begin
        raise[livet_pkg::SRC_PIN0 + i] = act && !q.prev[i];
      end
    end
    // error interrupt on any newly raised bit
    raise[livet_pkg::SRC_ERR] = |(new_err & ~q.acc);
    d.acc = d.acc | new_err;
    // latch edge events; a mask of one inhibits reception
    for (int i = 0; i < livet_pkg::NSRC; i++) begin
      if (raise[i] && !q.ent[i].mask) begin
        d.pend[i] = 1'b1;
      end
    end
    // synchronous reset: everything clear, sources masked
    if (sys_rst) begin
      d = '0;
      for (int i = 0; i < livet_pkg::NSRC; i++) begin
        d.ent[i].mask = livet_pkg::ENT_MASK_RST;
      end
    end
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= d;
  end

  // outputs straight from the state flops
  assign reg_rdata = q.rdata;
  assign reg_ack = q.ack;
  assign gp_fault = q.gp;
  assign del_valid = q.dv;
  assign del_vector = q.dvec;
  assign del_mode = q.dmode;
  assign del_src = q.dsrc;
  assign msg_valid = q.mv;
  assign msg_vector = q.mvec;
  assign msg_mode = q.mmode;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic esr_wr;
  logic icr_wr;
  logic init_wr;
  assign esr_wr = reg_wr && rgn == livet_pkg::OFF_ESR;
  assign icr_wr = reg_wr && rgn == livet_pkg::OFF_ICR;
  assign init_wr = reg_wr && rgn == livet_pkg::OFF_INIT;

  a_status_pending: assert property (
    del_valid |-> q.ent[del_src].stat)
    else $error("delivery without send pending status");
  a_accept_idle: assert property (
    del_valid && core_accept |=> !del_valid &&
      !q.ent[$past(del_src)].stat)
    else $error("status not idle after accept");
  a_legal_vector: assert property (
    del_valid && del_mode == livet_pkg::MODE_FIXED |->
      del_vector >= livet_pkg::VEC_MIN_LEGAL)
    else $error("illegal vector delivered");
  a_perf_mask: assert property (
    $rose(del_valid) && del_src == 3'(livet_pkg::SRC_PERF) |->
      q.ent[livet_pkg::SRC_PERF].mask)
    else $error("perf delivery left unmasked");
  a_oneshot_hold: assert property (
    !q.run && q.cur == '0 && !init_wr |=> q.cur == '0)
    else $error("stopped timer moved");
  a_periodic_reload: assert property (
    q.run && tick && q.cur == livet_pkg::CNT_ONE && !init_wr &&
      q.ent[livet_pkg::SRC_TIMER].tmode |=>
      q.cur == $past(q.init) && q.run)
    else $error("periodic timer did not reload");
  a_esr_update: assert property (
    esr_wr && !q.esr_last && !ext_mode |=> q.error_status_flags == $past(q.acc))
    else $error("error status not refreshed");
  a_esr_clear: assert property (
    esr_wr && q.esr_last && !ext_mode |=> q.error_status_flags == '0)
    else $error("back-to-back writes did not clear");
  a_redirect_err: assert property (
    icr_wr && reg_wdata[livet_pkg::F_MODE +: 3] ==
      livet_pkg::MODE_LOWEST |=> q.acc[livet_pkg::E_REDIR] &&
      !msg_valid && q.acc[livet_pkg::E_SILL] ==
      $past(q.acc[livet_pkg::E_SILL]))
    else $error("lowest priority command mishandled");
  a_ext_fault: assert property (
    ext_mode && esr_wr && reg_wdata != '0 |=> gp_fault)
    else $error("no fault on nonzero write");

  c_timer_fire: cover property (
    del_valid && del_src == 3'(livet_pkg::SRC_TIMER));
  c_perf_fire: cover property (
    del_valid && del_src == 3'(livet_pkg::SRC_PERF));
  c_esr_clear: cover property (esr_wr && q.esr_last);
  c_level_service: cover property (
    $rose(q.ent[livet_pkg::SRC_PIN0].lis));
endmodule

/* testbench/livet_core_model.sv */
// core-side model: takes offered interrupts and issues end of service
`timescale 1ns/100ps
module livet_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic del_valid,
  input wire logic [7:0] del_vector,
  input wire logic [2:0] del_mode,
  input wire logic [2:0] del_src,
  input wire logic slow,
  input wire logic eoi_go,
  output logic core_accept,
  output logic end_of_service_command,
  output logic [7:0] eoi_vector,
  output int acc_cnt,
  output logic [7:0] last_vec,
  output logic [2:0] last_src,
  output logic [2:0] last_mode
);
  int wait_r; // cycles the current offer has waited
  //----------
  // accept after 0 or 6 cycles, one offer at a time
  //----------
  always @(posedge clk) begin
    core_accept <= 1'b0;
    end_of_service_command <= eoi_go;
    // idle vector line toggles so a stale value never matches
    eoi_vector <= eoi_go ? last_vec : ~eoi_vector;
    if (sys_rst) begin
      acc_cnt <= 0;
      wait_r <= 0;
      last_vec <= 8'h00;
      last_src <= 3'h0;
      last_mode <= 3'h0;
      eoi_vector <= 8'h00;
      end_of_service_command <= 1'b0;
    end else if (del_valid && !core_accept) begin
      if (wait_r >= (slow ? 6 : 0)) begin
        core_accept <= 1'b1;
        acc_cnt <= acc_cnt + 1;
        last_vec <= del_vector;
        last_src <= del_src;
        last_mode <= del_mode;
        wait_r <= 0;
      end else begin
        wait_r <= wait_r + 1;
      end
    end
  end
endmodule

/* testbench/tb.sv */
// self-checking bench for the local interrupt, error and timer block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; \
  if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  typedef struct {logic [11:0] a; logic [31:0] d, e;} livet_row_t;
  typedef struct {logic [31:0] d; logic m; logic [31:0] e;} livet_cmd_t;
  logic clk, sys_rst, ext_mode, reg_wr, reg_rd, local_pin_zero;
  logic local_pin_one, thermal_evt, perf_evt, slow, eoi_go;
  logic reg_ack, gp_fault, del_valid, core_accept, msg_valid;
  logic end_of_service_command, cap_gp, cap_msg;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic [7:0] del_vector, eoi_vector, msg_vector, last_vec, cap_mvec;
  logic [2:0] del_mode, del_src, msg_mode, last_src, last_mode, cap_mmode;
  int acc_cnt, error_cnt, n_tests, cyc, c0, t0;
  // register rows: address, write data, read-back
  livet_row_t regs[7] = '{'{12'h330, 32'h00011030, 32'h00010030},
    '{12'h350, 32'h00014040, 32'h00010040},
    '{12'h320, 32'h00030055, 32'h00030055},
    '{12'h390, 32'h12345678, 32'h00000000},
    '{12'h380, 32'hFFFFFFFF, 32'hFFFFFFFF},
    '{12'h380, 32'h00000000, 32'h00000000},
    '{12'h320, 32'h00010000, 32'h00010000}};
  // command rows: data, message expected, error bits expected
  livet_cmd_t cmds[11] = '{'{32'h030, 1'b1, 32'h0},
    '{32'h010, 1'b1, 32'h0}, '{32'h01F, 1'b1, 32'h0},
    '{32'h0FF, 1'b1, 32'h0}, '{32'h00F, 1'b0, 32'h20},
    '{32'h130, 1'b0, 32'h10}, '{32'h105, 1'b0, 32'h10},
    '{32'h200, 1'b1, 32'h0}, '{32'h400, 1'b1, 32'h0},
    '{32'h500, 1'b1, 32'h0}, '{32'h700, 1'b1, 32'h0}};

  livet_top u_livet_top (.clk(clk), .sys_rst(sys_rst), .ext_mode(ext_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .gp_fault(gp_fault), .local_pin_zero(local_pin_zero),
    .local_pin_one(local_pin_one), .thermal_evt(thermal_evt),
    .perf_evt(perf_evt), .del_valid(del_valid), .del_vector(del_vector),
    .del_mode(del_mode), .del_src(del_src), .core_accept(core_accept),
    .end_of_service_command(end_of_service_command),
    .eoi_vector(eoi_vector), .msg_valid(msg_valid),
    .msg_vector(msg_vector), .msg_mode(msg_mode));
  livet_core_model u_livet_core_model (.clk(clk), .sys_rst(sys_rst),
    .del_valid(del_valid), .del_vector(del_vector), .del_mode(del_mode),
    .del_src(del_src), .slow(slow), .eoi_go(eoi_go),
    .core_accept(core_accept),
    .end_of_service_command(end_of_service_command),
    .eoi_vector(eoi_vector), .acc_cnt(acc_cnt), .last_vec(last_vec),
    .last_src(last_src), .last_mode(last_mode));

  // free-running clock and cycle count
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  //----------
  // bus tasks: one-cycle strobe, answer one cycle later
  //----------
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
    cap_gp = gp_fault;
    cap_msg = msg_valid;
    cap_mvec = msg_vector;
    cap_mmode = msg_mode;
    `CHK(reg_ack, 1'b1)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    acc(1'b0, a, 32'h0, r);
  endtask
  // write then read: the write refreshes the visible error bits
  task automatic esr_get(output logic [31:0] r);
    wr(livet_pkg::OFF_ESR, 32'h0);
    rd(livet_pkg::OFF_ESR, r);
  endtask
  task automatic esr_clr();
    wr(livet_pkg::OFF_ESR, 32'h0);
    wr(livet_pkg::OFF_ESR, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for the model to take a delivery
  task automatic wait_acc(input int lim);
    int k;
    c0 = acc_cnt;
    for (k = 0; k < lim && acc_cnt == c0; k++) @(posedge clk);
    #1;
    if (acc_cnt == c0) begin
      `CHK(acc_cnt, c0 + 1)
      print_verdict();
    end
  endtask
  task automatic chk_reset();
    for (int i = 0; i < livet_pkg::NSRC; i++) begin
      rd(livet_pkg::LVT_OFF[i], q);
      `CHK(q, {15'h0, livet_pkg::ENT_MASK_RST, 16'h0})
    end
    rd(livet_pkg::OFF_INIT, q);
    `CHK(q, 32'h0)
    esr_get(q);
    `CHK(q, 32'h0)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //----------
  // main sequence
  //----------
  initial begin
    {sys_rst, ext_mode, reg_wr, reg_rd, local_pin_zero} = 5'h10;
    {local_pin_one, thermal_evt, perf_evt, slow, eoi_go} = 5'h0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reset();
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rd(regs[i].a, q);
      `CHK(q, regs[i].e)
    end
    foreach (cmds[i]) begin
      esr_clr();
      wr(livet_pkg::OFF_ICR, cmds[i].d);
      `CHK(cap_msg, cmds[i].m)
      if (cmds[i].m) `CHK({cap_mmode, cap_mvec}, cmds[i].d[10:0])
      esr_get(q);
      `CHK(q, cmds[i].e)
    end
    // counter event with a slow core: pending status, self-mask
    slow <= 1'b1;
    wr(12'h340, 32'h50);
    @(posedge clk) perf_evt <= 1'b1;
    @(posedge clk) perf_evt <= 1'b0;
    idle(1);
    `CHK(del_valid, 1'b1)
    rd(12'h340, q);
    `CHK(q, 32'h00011050)
    wait_acc(20);
    `CHK({last_src, last_vec, last_mode}, 14'h1280)
    idle(2);
    rd(12'h340, q);
    `CHK(q, 32'h00010050)
    c0 = acc_cnt;
    @(posedge clk) perf_evt <= 1'b1;
    @(posedge clk) perf_evt <= 1'b0;
    idle(10);
    `CHK(acc_cnt, c0)
    slow <= 1'b0;
    // illegal fixed vector from a local source: flag only
    wr(12'h330, 32'h0F);
    esr_clr();
    c0 = acc_cnt;
    @(posedge clk) thermal_evt <= 1'b1;
    @(posedge clk) thermal_evt <= 1'b0;
    idle(10);
    `CHK(acc_cnt, c0)
    esr_get(q);
    `CHK(q, 32'h40)
    esr_get(q);
    `CHK(q, 32'h40)
    wr(12'h330, 32'h10000);
    // active-low level pin with in-service flag
    local_pin_zero <= 1'b1;
    idle(4);
    wr(12'h350, 32'hA060);
    c0 = acc_cnt;
    idle(10);
    `CHK(acc_cnt, c0)
    local_pin_zero <= 1'b0;
    wait_acc(20);
    `CHK({last_src, last_vec}, 11'h360)
    idle(2);
    rd(12'h350, q);
    `CHK(q, 32'h0000E060)
    c0 = acc_cnt;
    idle(10);
    `CHK(acc_cnt, c0)
    @(posedge clk) eoi_go <= 1'b1;
    @(posedge clk) eoi_go <= 1'b0;
    wait_acc(20);
    local_pin_zero <= 1'b1;
    idle(4);
    @(posedge clk) eoi_go <= 1'b1;
    @(posedge clk) eoi_go <= 1'b0;
    idle(3);
    rd(12'h350, q);
    `CHK(q, 32'h0000A060)
    wr(12'h350, 32'h10000);
    // edge pin held high gives one delivery; external_controller_delivery stays level
    wr(12'h360, 32'h70);
    c0 = acc_cnt;
    local_pin_one <= 1'b1;
    idle(30);
    `CHK(acc_cnt, c0 + 1)
    wr(12'h360, 32'h700);
    wait_acc(20);
    `CHK(last_mode, 3'h7)
    wait_acc(20);
    local_pin_one <= 1'b0;
    wr(12'h360, 32'h10000);
    idle(10);
    // one-shot timer, restarted mid-count, then holds at zero
    wr(12'h320, 32'h80);
    wr(12'h380, 32'd40);
    idle(20);
    wr(12'h380, 32'd40);
    c0 = acc_cnt;
    idle(30);
    `CHK(acc_cnt, c0)
    wait_acc(30);
    `CHK({last_src, last_vec}, 11'h080)
    c0 = acc_cnt;
    idle(60);
    `CHK(acc_cnt, c0)
    rd(12'h390, q);
    `CHK(q, 32'h0)
    // periodic timer: period follows count and divider
    wr(12'h320, 32'h20080);
    wr(12'h380, 32'd10);
    wait_acc(40);
    t0 = cyc;
    wait_acc(40);
    `CHK(cyc - t0, 10)
    wr(12'h3E0, 32'h1);
    wait_acc(60);
    wait_acc(60);
    t0 = cyc;
    wait_acc(60);
    `CHK(cyc - t0, 20)
    wr(12'h380, 32'h0);
    c0 = acc_cnt;
    idle(40);
    `CHK(acc_cnt, c0)
    wr(12'h320, 32'h10000);
    wr(12'h3E0, 32'h0);
    // reserved address: error bit and error interrupt, then fault mode
    wr(12'h370, 32'h90);
    esr_clr();
    rd(12'h3A0, q);
    `CHK(q, 32'h0)
    wait_acc(20);
    `CHK({last_src, last_vec}, 11'h590)
    esr_get(q);
    `CHK(q, 32'h80)
    esr_clr();
    ext_mode <= 1'b1;
    rd(12'h3A0, q);
    `CHK(cap_gp, 1'b1)
    wr(livet_pkg::OFF_ESR, 32'h1);
    `CHK(cap_gp, 1'b1)
    wr(livet_pkg::OFF_ESR, 32'h0);
    `CHK(cap_gp, 1'b0)
    esr_get(q);
    `CHK(q, 32'h0)
    ext_mode <= 1'b0;
    // second reset in mid-run
    sys_rst <= 1'b1;
    idle(3);
    sys_rst <= 1'b0;
    chk_reset();
    print_verdict();
  end
endmodule
